/* File: bench/adc_conversion_control_tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
  import adcc_pkg::*;
  logic sys_clk, reset_n, av_rd, av_wr, trig, slow, done, wait_req, irq;
  logic conv_clk, conv_start, ck_q;
  logic [7:0] av_addr;
  logic [31:0] av_wdata, av_rdata, d;
  logic [DATA_W-1:0] conv_data;
  logic [4:0] c;
  adcc_mux_s mux;
  int bad_count, tests_run, starts, rises, cyc, n0;
  logic [4:0] pos_seen[$];
  logic [4:0] codes[8] = '{5'h00, 5'h07, 5'h08, 5'h17, 5'h18, 5'h19,
                           5'h1a, 5'h1f};
  logic [7:0] regs[4] = '{8'h08, 8'h10, 8'h14, 8'h18};

  adcc_control #(.SYNC_LEN(1)) i_adcc_control (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(wait_req), .conv_clk_o(conv_clk),
    .conv_start_o(conv_start), .conv_mux_o(mux), .conv_done_i(done),
    .conv_data_i(conv_data), .trig_i(trig), .irq_o(irq));

  adcc_core_model i_adcc_core_model (
    .clk_i(sys_clk), .reset_n_i(reset_n), .start_i(conv_start),
    .mux_i(mux), .slow_i(slow), .done_o(done), .data_o(conv_data));

  function automatic logic [11:0] exp_data(input logic [4:0] p);
    return {p, 7'h2b};
  endfunction

  function automatic logic nv(input logic [4:0] n);
    return (n <= 5'h07) || (n == 5'h18) || (n == 5'h19);
  endfunction

  function automatic logic [31:0] sel(input logic [4:0] p, n,
                                      input logic [3:0] cn, o);
    return {8'h00, o, cn, 3'h0, n, 3'h0, p};
  endfunction

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v, output logic [31:0] q);
    av_addr <= a;
    av_wdata <= v;
    if (w) av_wr <= 1'b1;
    else av_rd <= 1'b1;
    do @(posedge sys_clk); while (wait_req !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic conv;
    logic [31:0] f;
    int n;
    n = 0;
    f = 32'h0;
    slow <= 1'($urandom % 2);
    wr(OFS_CONVERTER_IRQ_FLAGS, 32'h1);
    wr(OFS_SOFTWARE_TRIGGER_REG, 32'h1);
    while (f[0] !== 1'b1 && n < 40) begin
      rd(OFS_CONVERTER_IRQ_FLAGS, f);
      n++;
    end
    check(f[0], 1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Start, prescaled clock and timeout bookkeeping
  always @(posedge sys_clk) begin
    ck_q <= conv_clk;
    if (conv_clk === 1'b1 && ck_q === 1'b0) rises <= rises + 1;
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      pos_seen.push_back(mux.pos);
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    reset_n = 1'b0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 8'h00;
    av_wdata = 32'h0;
    trig = 1'b0;
    slow = 1'b0;
    void'($urandom(32'hde3bfcc2));
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_CONVERTER_IRQ_FLAGS, d);
    check(d, 32'h0);
    rd(8'h3c, d);
    check(d, 32'h0);
    wr(OFS_CONTROL_A_REG, 32'h2);
    repeat (4) @(posedge sys_clk);
    rd(OFS_CONVERTER_IRQ_FLAGS, d);
    check(d, 32'h0);
    wr(OFS_INPUT_SELECT_CONTROL, sel(5'h02, 5'h18, 4'h0, 4'h0));
    repeat (4) @(posedge sys_clk);
    rd(OFS_CONVERTER_IRQ_FLAGS, d);
    check(d, 32'h8);
    wr(OFS_CONVERTER_IRQ_FLAGS, 32'h8);
    conv();
    check(mux.pos, 5'h02);
    rd(OFS_RESULT_REG, d);
    check(d[11:0], exp_data(5'h02));
    check(irq, 1'b0);
    wr(OFS_CONVERTER_IRQ_ENABLE_SET, 32'h1);
    check(irq, 1'b1);
    wr(OFS_CONVERTER_IRQ_ENABLE_SET, 32'h0);
    rd(OFS_IRQ_ENABLE_CLEAR_REG, d);
    check(d, 32'h1);
    wr(OFS_CONVERTER_IRQ_FLAGS, 32'h1);
    check(irq, 1'b0);
    wr(OFS_IRQ_ENABLE_CLEAR_REG, 32'h1);
    rd(OFS_IRQ_ENABLE_CLEAR_REG, d);
    check(d, 32'h0);
    // Scan of three inputs from pin 2 to pin 4, results left unread
    wr(OFS_INPUT_SELECT_CONTROL, sel(5'h01, 5'h00, 4'h2, 4'h1));
    pos_seen.delete();
    repeat (4) conv();
    check(pos_seen.size(), 4);
    for (int i = 0; i < 4; i++) begin
      check(pos_seen[i], (i < 3) ? 5'(2 + i) : 5'h01);
    end
    check(pos_seen[3], 5'h01);
    rd(OFS_CONVERTER_IRQ_FLAGS, d);
    check(d[1], 1'b1);
    rd(OFS_RESULT_REG, d);
    check(d[11:0], exp_data(5'h01));
    // Window covering every value flags a match; enable gates it
    wr(OFS_WINDOW_BOUNDS_REG, 32'h0fff0000);
    wr(OFS_WINDOW_CTRL_REG, 32'h1);
    conv();
    rd(OFS_CONVERTER_IRQ_FLAGS, d);
    check({d[2], irq}, 2'h2);
    wr(OFS_CONVERTER_IRQ_ENABLE_SET, 32'h4);
    check(irq, 1'b1);
    for (int i = 0; i < 12; i++) begin
      c = (i < 8) ? codes[i] : 5'($urandom % 32);
      wr(OFS_INPUT_SELECT_CONTROL, sel(5'h00, c, 4'h0, 4'h0));
      conv();
      check(mux.pos, 5'h00);
      check(mux.neg, c);
      check(mux.neg_valid, nv(c));
    end
    n0 = starts;
    wr(OFS_CONTROL_A_REG, 32'h6);
    wr(OFS_SOFTWARE_TRIGGER_REG, 32'h1);
    repeat (60) @(posedge sys_clk);
    check(starts - n0 >= 4, 1'b1);
    wr(OFS_CONTROL_A_REG, 32'h0);
    @(posedge sys_clk);
    n0 = starts;
    wr(OFS_SOFTWARE_TRIGGER_REG, 32'h1);
    repeat (30) @(posedge sys_clk);
    check(starts, n0);
    wr(OFS_CONTROL_A_REG, 32'ha);
    repeat (20) @(posedge sys_clk);
    n0 = starts;
    trig <= 1'b1;
    repeat (8) @(posedge sys_clk);
    trig <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check(starts - n0, 1);
    for (int p = 0; p < 3; p++) begin
      wr(OFS_PRESCALER_REG, 32'(p));
      repeat (8) @(posedge sys_clk);
      n0 = rises;
      repeat (32) @(posedge sys_clk);
      check(rises - n0, 32 >> (p + 1));
    end
    // Soft reset keeps debug control only
    wr(OFS_DEBUG_CONTROL_REG, 32'h1);
    wr(OFS_CONTROL_A_REG, 32'h0);
    wr(OFS_CONTROL_A_REG, 32'h1);
    repeat (4) @(posedge sys_clk);
    foreach (regs[i]) begin
      rd(regs[i], d);
      check(d, 32'h0);
    end
    rd(OFS_DEBUG_CONTROL_REG, d);
    check(d[0], 1'b1);
    check(conv_clk, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: bench/adcc_core_model.sv */
// Behavioural conversion core that answers start pulses with a result
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire adcc_pkg::adcc_mux_s mux_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [adcc_pkg::DATA_W-1:0] data_o
);
  import adcc_pkg::*;
  logic [4:0] cnt;
  logic [2:0] hold;
  logic [4:0] pos_q;
  // Done stands six cycles with data stable; released data is inverted
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 5'h00;
      hold <= 3'h0;
      pos_q <= 5'h00;
      done_o <= 1'b0;
      data_o <= 12'h000;
    end else begin
      if (start_i) begin
        cnt <= slow_i ? 5'h0c : 5'h03;
        pos_q <= mux_i.pos;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
      if (cnt == 5'h01 && !start_i) begin
        done_o <= 1'b1;
        data_o <= {pos_q, 7'h2b};
        hold <= 3'h6;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
        done_o <= (hold != 3'h1);
        if (hold == 3'h1) data_o <= ~data_o;
      end
    end
  end
endmodule
`default_nettype wire

/* File: pkg/adcc_pkg.sv */
// Constants, register map and carrier types of the converter control block
// Summary of operation
// [RULE1] Writing 1 to enable turns the converter on; writing 0 turns it off.
// [RULE2] Soft reset returns all registers but debug control to reset, disabled.
// [RULE3] Software disables the converter before issuing a soft reset.
// [RULE4] Conversion starts on software start bit or on an automatic trigger.
// [RULE5] Free-running: software starts the first, each end starts the next.
// [RULE6] Every finished conversion overwrites the result register.
// [RULE7] A new result before the pending one is read sets result-lost.
// [RULE8] Result-ready rises only once the result register holds the value.
// [RULE9] Conversion clock comes from the input clock through a prescaler.
// [RULE10] First conversion uses positive select plus scan offset.
// [RULE11] After each conversion the scan offset increments by one.
// [RULE12] Scan covers count plus one inputs; active when count is nonzero.
// [RULE13] Software keeps the scan range within the existing input channels.
// [RULE14] Negative codes 0-7 pins, 0x18 internal ground, 0x19 I/O ground.
// [RULE15] Positive select bits 4:0 choose the positive input.
// [RULE16] Software sets sampling length for bandgap or temperature inputs.
// [RULE17] Enable-set writes of 1 enable an interrupt; 0 changes nothing.
// [RULE18] A flag raises the request only while its enable bit is one.
// [RULE19] Flag register at 0x18 resets to zero; flags clear on writing 1.
// [RULE20] Sync-done sets when sync busy falls, unless enable or soft reset.
// [RULE21] After the last scan input the offset returns to zero.
// [RULE22] Starts are ignored while disabled; a running conversion completes. Here disabling drops it to idle and its result is not captured.
package adcc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 12;

  localparam logic [7:0] OFS_CONTROL_A_REG = 8'h00;
  localparam logic [7:0] OFS_DEBUG_CONTROL_REG = 8'h04;
  localparam logic [7:0] OFS_PRESCALER_REG = 8'h08;
  localparam logic [7:0] OFS_SOFTWARE_TRIGGER_REG = 8'h0c;
  localparam logic [7:0] OFS_INPUT_SELECT_CONTROL = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR_REG = 8'h14;
  localparam logic [7:0] OFS_CONVERTER_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] OFS_CONVERTER_IRQ_ENABLE_SET = 8'h1c;
  localparam logic [7:0] OFS_STATUS_REG = 8'h20;
  localparam logic [7:0] OFS_RESULT_REG = 8'h24;
  localparam logic [7:0] OFS_WINDOW_CTRL_REG = 8'h28;
  localparam logic [7:0] OFS_WINDOW_BOUNDS_REG = 8'h2c;

  localparam int CTL_SOFT_RESET_BIT_BIT = 0;
  localparam int CTL_ENABLE_BIT = 1;
  localparam int CTL_FREERUN_BIT = 2;
  localparam int CTL_AUTOTRIG_BIT = 3;
  localparam int TRIG_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SYNC_BIT = 7;
  localparam int WIN_EN_BIT = 0;
  localparam int WIN_HI_LSB = 16;

  localparam int FLG_RESULT_READY = 0;
  localparam int FLG_RESULT_LOST = 1;
  localparam int FLG_WINDOW_MATCH = 2;
  localparam int FLG_SYNC_DONE = 3;
  localparam int FLG_W = 4;

  localparam int POS_LSB = 0;
  localparam int NEG_LSB = 8;
  localparam int SCAN_LSB = 16;
  localparam int OFFSET_LSB = 20;

  localparam logic [4:0] NEG_PIN_MAX_CODE = 5'h07;
  localparam logic [4:0] NEG_INT_GROUND_CODE = 5'h18;
  localparam logic [4:0] IO_GROUND_CODE = 5'h19;

  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [2:0] PRESC_RESET = 3'h0;

  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_TIME_NS = 60;
  localparam int SYNC_CYCLES =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [4:0] pos;
    logic [4:0] neg;
    logic neg_valid;
  } adcc_mux_s;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONV
  } adcc_state_e;

endpackage

/* File: src/adcc_control.sv */
// Converter control: register slave, start logic, scan, result and flags
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adcc_control #(
  parameter int SYNC_LEN = adcc_pkg::SYNC_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [adcc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic conv_clk_o,
  output logic conv_start_o,
  output adcc_pkg::adcc_mux_s conv_mux_o,
  input wire logic conv_done_i,
  input wire logic [adcc_pkg::DATA_W-1:0] conv_data_i,
  input wire logic trig_i,
  output logic irq_o
);
  import adcc_pkg::*;

  if (SYNC_LEN < 1 || SYNC_LEN > 255) begin : g_sync_len
    $error("SYNC_LEN out of range");
  end

  // Register state
  logic enable, free_run, auto_trig, dbg_run, win_en;
  logic [2:0] presc;
  logic [3:0] scan_offset, scan_count, scan_done;
  logic [4:0] pos_sel, neg_sel;
  logic [DATA_W-1:0] win_lo, win_hi, result;
  logic [FLG_W-1:0] irq_en, irq_flag;
  logic pending, pend_start, ack, sync_quiet;
  logic [7:0] sync_cnt;
  logic [8:0] psc_cnt;
  logic done_meta, done_sync, done_prev;
  logic trig_meta, trig_sync, trig_prev;
  adcc_state_e state;

  // Bus decode
  wire req = avs_read_i | avs_write_i;
  wire wr_fire = avs_write_i & ack;
  wire rd_fire = avs_read_i & ack;
  wire [31:0] wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wd = avs_writedata_i & wmask;
  wire wr_ctrl = wr_fire && avs_address_i == OFS_CONTROL_A_REG;
  wire wr_dbg = wr_fire && avs_address_i == OFS_DEBUG_CONTROL_REG;
  wire wr_presc = wr_fire && avs_address_i == OFS_PRESCALER_REG;
  wire wr_trig = wr_fire && avs_address_i == OFS_SOFTWARE_TRIGGER_REG;
  wire wr_input = wr_fire && avs_address_i == OFS_INPUT_SELECT_CONTROL;
  wire wr_ienclr = wr_fire && avs_address_i == OFS_IRQ_ENABLE_CLEAR_REG;
  wire wr_flags = wr_fire && avs_address_i == OFS_CONVERTER_IRQ_FLAGS;
  wire wr_ienset = wr_fire && avs_address_i == OFS_CONVERTER_IRQ_ENABLE_SET;
  wire wr_winctl = wr_fire && avs_address_i == OFS_WINDOW_CTRL_REG;
  wire wr_winbnd = wr_fire && avs_address_i == OFS_WINDOW_BOUNDS_REG;
  wire rd_result = rd_fire && avs_address_i == OFS_RESULT_REG;
  wire soft_rst = wr_ctrl & wd[CTL_SOFT_RESET_BIT_BIT]; // [RULE2]
  wire sync_busy = sync_cnt != 8'h00;
  wire [31:0] input_word = {8'h00, scan_offset, scan_count, 3'h0, neg_sel,
                            3'h0, pos_sel};
  wire [31:0] input_new = (input_word & ~wmask) | wd;
  wire [31:0] bounds_word = {4'h0, win_hi, 4'h0, win_lo};
  wire [31:0] bounds_new = (bounds_word & ~wmask) | wd;
  wire [31:0] ctrl_word = {28'h0, auto_trig, free_run, enable, 1'b0};
  wire [31:0] status_word = {24'h0, sync_busy, 6'h0, state == ST_CONV};

  wire [31:0] rd_val =
    avs_address_i == OFS_CONTROL_A_REG ? ctrl_word :
    avs_address_i == OFS_DEBUG_CONTROL_REG ? {31'h0, dbg_run} :
    avs_address_i == OFS_PRESCALER_REG ? {29'h0, presc} :
    avs_address_i == OFS_INPUT_SELECT_CONTROL ? input_word :
    avs_address_i == OFS_IRQ_ENABLE_CLEAR_REG ? {28'h0, irq_en} :
    avs_address_i == OFS_CONVERTER_IRQ_FLAGS ? {28'h0, irq_flag} :
    avs_address_i == OFS_CONVERTER_IRQ_ENABLE_SET ? {28'h0, irq_en} :
    avs_address_i == OFS_STATUS_REG ? status_word :
    avs_address_i == OFS_RESULT_REG ? {20'h0, result} :
    avs_address_i == OFS_WINDOW_CTRL_REG ? {31'h0, win_en} :
    avs_address_i == OFS_WINDOW_BOUNDS_REG ? bounds_word : 32'h0;

  // One wait state on every access
  assign avs_waitrequest_o = req & ~ack;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (avs_read_i & ~ack) begin
        avs_readdata_o <= rd_val;
      end
    end
  end

  // Input synchronisers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      done_meta <= conv_done_i;
      done_sync <= done_meta;
      done_prev <= done_sync;
      trig_meta <= trig_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  wire done_edge = done_sync & ~done_prev;
  wire trig_edge = trig_sync & ~trig_prev;
  wire conv_end = done_edge && state == ST_CONV;
  wire sw_start = wr_trig & wd[TRIG_START_BIT];
  wire start_req = sw_start | (auto_trig & trig_edge) | pend_start; // [RULE4]
  wire scan_on = scan_count != 4'h0; // [RULE12]
  wire scan_last = scan_done == scan_count;
  wire in_window = result_in_win(conv_data_i, win_lo, win_hi);
  function automatic logic result_in_win(input logic [DATA_W-1:0] v,
                                         input logic [DATA_W-1:0] lo,
                                         input logic [DATA_W-1:0] hi);
    result_in_win = (v >= lo) && (v <= hi);
  endfunction

  // Control registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable <= 1'b0;
      free_run <= 1'b0;
      auto_trig <= 1'b0;
      presc <= PRESC_RESET;
      win_en <= 1'b0;
      win_lo <= '0;
      win_hi <= '0;
    end else if (soft_rst) begin
      enable <= 1'b0;
      free_run <= 1'b0;
      auto_trig <= 1'b0;
      presc <= PRESC_RESET;
      win_en <= 1'b0;
      win_lo <= '0;
      win_hi <= '0;
    end else begin
      if (wr_ctrl & avs_byteenable_i[0]) begin
        enable <= wd[CTL_ENABLE_BIT]; // [RULE1]
        free_run <= wd[CTL_FREERUN_BIT];
        auto_trig <= wd[CTL_AUTOTRIG_BIT];
      end
      if (wr_presc & avs_byteenable_i[0]) begin
        presc <= wd[2:0];
      end
      if (wr_winctl & avs_byteenable_i[0]) begin
        win_en <= wd[WIN_EN_BIT];
      end
      if (wr_winbnd) begin
        win_lo <= bounds_new[DATA_W-1:0];
        win_hi <= bounds_new[WIN_HI_LSB +: DATA_W];
      end
    end
  end

  // Debug control survives soft reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbg_run <= 1'b0;
    end else if (wr_dbg & avs_byteenable_i[0]) begin
      dbg_run <= wd[0]; // [RULE2]
    end
  end

  // Input selection and scan
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_sel <= 5'h0;
      neg_sel <= 5'h0;
      scan_count <= 4'h0;
      scan_offset <= 4'h0;
      scan_done <= 4'h0;
    end else if (soft_rst) begin
      pos_sel <= 5'h0;
      neg_sel <= 5'h0;
      scan_count <= 4'h0;
      scan_offset <= 4'h0;
      scan_done <= 4'h0;
    end else if (wr_input) begin
      pos_sel <= input_new[POS_LSB +: 5]; // [RULE15]
      neg_sel <= input_new[NEG_LSB +: 5];
      scan_count <= input_new[SCAN_LSB +: 4];
      scan_offset <= input_new[OFFSET_LSB +: 4];
      scan_done <= 4'h0;
    end else if (conv_end && scan_on) begin
      if (scan_last) begin
        scan_offset <= 4'h0; // [RULE21]
        scan_done <= 4'h0;
      end else begin
        scan_offset <= scan_offset + 4'h1; // [RULE11]
        scan_done <= scan_done + 4'h1;
      end
    end
  end

  // Conversion sequencing
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      pend_start <= 1'b0;
      conv_start_o <= 1'b0;
      conv_mux_o <= '0;
    end else if (soft_rst || !enable) begin
      state <= ST_IDLE; // [RULE22]
      pend_start <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            state <= ST_CONV;
            pend_start <= 1'b0;
            conv_start_o <= 1'b1;
            conv_mux_o.pos <= pos_sel + {1'b0, scan_offset}; // [RULE10]
            conv_mux_o.neg <= neg_sel;
            conv_mux_o.neg_valid <= neg_sel <= NEG_PIN_MAX_CODE ||
              neg_sel == NEG_INT_GROUND_CODE ||
              neg_sel == IO_GROUND_CODE; // [RULE14]
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state <= ST_IDLE;
            pend_start <= pend_start | free_run | sw_start |
                          (auto_trig & trig_edge); // [RULE5]
          end else if (sw_start | (auto_trig & trig_edge)) begin
            pend_start <= 1'b1; // [RULE22]
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Result capture and unread tracking
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result <= '0;
      pending <= 1'b0;
    end else if (soft_rst) begin
      result <= '0;
      pending <= 1'b0;
    end else if (conv_end) begin
      result <= conv_data_i; // [RULE6]
      pending <= 1'b1;
    end else if (rd_result) begin
      pending <= 1'b0;
    end
  end

  // Sync busy: writes to synchronised registers
  wire sync_trigger = wr_ctrl | wr_input | wr_winctl | wr_winbnd;
  wire quiet_cause = soft_rst |
    (wr_ctrl && wd[CTL_ENABLE_BIT] != enable);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_cnt <= 8'h00;
      sync_quiet <= 1'b0;
    end else if (sync_trigger) begin
      sync_cnt <= 8'(SYNC_LEN);
      sync_quiet <= quiet_cause;
    end else if (sync_busy) begin
      sync_cnt <= sync_cnt - 8'h01;
    end
  end
  wire sync_fall = sync_cnt == 8'h01 && !sync_trigger;

  // Flag events, set beats clear
  wire [FLG_W-1:0] flag_set = {
    sync_fall & ~sync_quiet, // [RULE20]
    conv_end & win_en & in_window,
    conv_end & pending & ~rd_result, // [RULE7]
    conv_end // [RULE8]
  };
  wire [FLG_W-1:0] flag_clr = wr_flags ? wd[FLG_W-1:0] : '0;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_flag <= FLAGS_RESET;
      irq_en <= '0;
    end else if (soft_rst) begin
      irq_flag <= FLAGS_RESET;
      irq_en <= '0;
    end else begin
      irq_flag <= (irq_flag & ~flag_clr) | flag_set; // [RULE19]
      if (wr_ienset) begin
        irq_en <= irq_en | wd[FLG_W-1:0]; // [RULE17]
      end else if (wr_ienclr) begin
        irq_en <= irq_en & ~wd[FLG_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_flag & irq_en); // [RULE18]
  // Prescaler: half period of 2^presc cycles
  wire [8:0] psc_limit = 9'((9'h1 << presc) - 9'h1);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psc_cnt <= 9'h0;
      conv_clk_o <= 1'b0;
    end else if (!enable || soft_rst) begin
      psc_cnt <= 9'h0;
      conv_clk_o <= 1'b0;
    end else if (psc_cnt >= psc_limit) begin
      psc_cnt <= 9'h0;
      conv_clk_o <= ~conv_clk_o; // [RULE9]
    end else begin
      psc_cnt <= psc_cnt + 9'h1;
    end
  end

  // Checks
  sequence conv_finish_s;
    conv_end && free_run && enable && !wr_ctrl;
  endsequence
  sequence restart_s;
    ##[1:3] conv_start_o;
  endsequence
  free_restart_a: assert property (@(posedge sys_clk_i) // [RULE5]
    disable iff (!reset_n_i)
    conv_finish_s ##1 !wr_ctrl |-> restart_s)
    else $error("free-running restart missing");
  result_ready_a: assert property (@(posedge sys_clk_i) // [RULE8]
    disable iff (!reset_n_i)
    conv_end && !soft_rst |=>
      irq_flag[FLG_RESULT_READY] && result == $past(conv_data_i))
    else $error("result or ready flag wrong after conversion");
  overrun_a: assert property (@(posedge sys_clk_i) // [RULE7]
    disable iff (!reset_n_i)
    conv_end && pending && !rd_result && !soft_rst |=>
      irq_flag[FLG_RESULT_LOST])
    else $error("lost result not flagged");
  flag_clear_a: assert property (@(posedge sys_clk_i) // [RULE19]
    disable iff (!reset_n_i)
    wr_flags && wd[FLG_RESULT_READY] && !conv_end |=>
      !irq_flag[FLG_RESULT_READY])
    else $error("ready flag not cleared by write of one");
  ien_set_a: assert property (@(posedge sys_clk_i) // [RULE17]
    disable iff (!reset_n_i)
    wr_ienset && !soft_rst |=>
      (irq_en & $past(wd[FLG_W-1:0])) == $past(wd[FLG_W-1:0]) &&
      (irq_en | $past(irq_en)) == irq_en)
    else $error("enable-set write misbehaves");
  irq_gate_a: assert property (@(posedge sys_clk_i) // [RULE18]
    disable iff (!reset_n_i)
    wr_ienclr && (irq_en & ~wd[FLG_W-1:0]) == '0 |=> !irq_o)
    else $error("request without enabled flag");
  start_enabled_a: assert property (@(posedge sys_clk_i) // [RULE22]
    disable iff (!reset_n_i)
    conv_start_o |-> $past(enable) && $past(state) == ST_IDLE)
    else $error("start while disabled or busy");
  mux_sum_a: assert property (@(posedge sys_clk_i) // [RULE10]
    disable iff (!reset_n_i)
    conv_start_o |->
      conv_mux_o.pos == 5'($past(pos_sel) + {1'b0, $past(scan_offset)}))
    else $error("positive input not select plus offset");
  scan_step_a: assert property (@(posedge sys_clk_i) // [RULE11]
    disable iff (!reset_n_i)
    conv_end && scan_on && !scan_last && !wr_input && !soft_rst |=>
      scan_offset == 4'($past(scan_offset) + 4'h1))
    else $error("scan offset did not advance");
  soft_reset_a: assert property (@(posedge sys_clk_i) // [RULE2]
    disable iff (!reset_n_i)
    soft_rst |=> !enable && irq_flag[2:0] == 3'h0 && irq_en == '0 &&
      dbg_run == $past(dbg_run))
    else $error("soft reset did not restore registers");
  sync_done_a: assert property (@(posedge sys_clk_i) // [RULE20]
    disable iff (!reset_n_i)
    sync_fall && !sync_quiet && !soft_rst |=> irq_flag[FLG_SYNC_DONE])
    else $error("sync done not flagged");
  enable_write_a: assert property (@(posedge sys_clk_i) // [RULE1]
    disable iff (!reset_n_i)
    wr_ctrl && avs_byteenable_i[0] && !soft_rst |=>
      enable == $past(wd[CTL_ENABLE_BIT]))
    else $error("enable bit not taken");
endmodule
`default_nettype wire
